// [design/rss_pkg.sv]
package rss_pkg;
   // ***************************
   // Register map
   // ***************************
   localparam logic [7:0] RSS_ADDR_CFG = 8'h00;
   localparam logic [7:0] RSS_ADDR_PWRCTL = 8'h04;
   localparam logic [7:0] RSS_ADDR_CORE = 8'h08;
   localparam logic [7:0] RSS_ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] RSS_ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] RSS_ADDR_STATE = 8'h14;

   // ***************************
   // Field layouts
   // ***************************
   typedef struct packed {
      logic gpio_pullup_sw;
      logic powerup_delay_enable;
      logic stack_fault_reset_enable;
      logic low_voltage_program_enable;
      logic ext_reset_pin_enable;
      logic [1:0] supply_monitor_mode;
      logic low_power_supply_monitor;
   } rss_cfg_t;

   typedef struct packed {
      logic stack_over_flag;
      logic stack_under_flag;
      logic reset_instr_flag;
      logic power_on_flag;
      logic brownout_cause_flag;
   } rss_pwrctl_t;

   typedef struct packed {
      logic watchdog_expired_flag;
      logic powerdown_flag;
   } rss_core_t;

   typedef struct packed {
      logic prog_exit;
      logic stack_under;
      logic stack_over;
      logic reset_instr;
      logic watchdog_timeout;
   } rss_src_t;

   localparam int RSS_EV_W = 7;
   localparam int RSS_EV_BROWNOUT = 0;
   localparam int RSS_EV_PIN = 1;
   localparam int RSS_EV_WATCHDOG = 2;
   localparam int RSS_EV_INSTR = 3;
   localparam int RSS_EV_OVER = 4;
   localparam int RSS_EV_UNDER = 5;
   localparam int RSS_EV_PROG = 6;

   // ***************************
   // Reset values
   // ***************************
   localparam rss_cfg_t RSS_CFG_RST = 8'h3E;
   localparam rss_pwrctl_t RSS_PWRCTL_RST = 5'h0D;
   localparam rss_core_t RSS_CORE_RST = 2'h3;
   localparam logic [1:0] RSS_MODE_OFF = 2'h0;
   localparam logic [1:0] RSS_MODE_SLEEP_OFF = 2'h2;

   typedef enum {ST_HOLD, ST_PWRT, ST_PIN, ST_DELAY, ST_RUN} rss_state_t;

   // ***************************
   // Timing
   // ***************************
   localparam int RSS_CLK_MHZ = 100;
   localparam int RSS_PWRT_TIME_MS = 64;
   localparam int RSS_PWRT_CYCLES = RSS_PWRT_TIME_MS * 1000 * RSS_CLK_MHZ;
   localparam int RSS_FILT_TIME_NS = 200;
   localparam int RSS_FILT_CYCLES = (RSS_FILT_TIME_NS * RSS_CLK_MHZ + 999) / 1000;
   localparam logic [3:0] RSS_START_DELAY = 4'hA;
endpackage

// [design/rss_glitch_filter.sv]
`timescale 1ns/1ns
module rss_glitch_filter
   import rss_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic raw_lvl,
   output logic filt_lvl
);
   logic [7:0] cnt_reg;

   // ***************************
   // Level must stay put for the full window before it is taken
   // ***************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_reg <= 8'h00;
         filt_lvl <= 1'b1;
      end else if (raw_lvl == filt_lvl) begin
         cnt_reg <= 8'h00;
      end else if (cnt_reg == 8'(RSS_FILT_CYCLES - 1)) begin
         cnt_reg <= 8'h00;
         filt_lvl <= raw_lvl;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule // rss_glitch_filter

// [design/rss_powerup_timer.sv]
`timescale 1ns/1ns
module rss_powerup_timer
   import rss_pkg::*;
#(
   parameter int PWRT_CYCLES = RSS_PWRT_CYCLES
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic start,
   input wire logic enable,
   output logic done
);
   logic [31:0] cnt_reg;

   // ***************************
   // Counts from start; a disabled timer is done at once
   // ***************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_reg <= 32'h0000_0000;
         done <= 1'b0;
      end else if (start) begin
         cnt_reg <= 32'h0000_0000;
         done <= ~enable;
      end else if (!done) begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
         if (cnt_reg == 32'(PWRT_CYCLES - 1)) begin
            done <= 1'b1;
         end
      end
   end
endmodule // rss_powerup_timer

// [design/rss_sequencer.sv]
`timescale 1ns/1ns
module rss_sequencer
   import rss_pkg::*;
#(
   parameter int PWRT_CYCLES = RSS_PWRT_CYCLES
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_low_async,
   input wire logic lp_supply_low_async,
   input wire logic sleep_active,
   input wire logic ext_reset_pin_in,
   output logic ext_reset_pin_out,
   output logic ext_reset_pin_oe,
   output logic ext_reset_pin_pullup,
   output logic gpio_in_lvl,
   input wire rss_src_t reset_src,
   output logic core_reset,
   output logic irq
);
   // ***************************
   // Input synchronisers
   // ***************************
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic pin_filt;
   logic pwrt_done;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
      end else begin
         sync1_reg <= {ext_reset_pin_in, ~lp_supply_low_async, ~supply_low_async};
         sync2_reg <= sync1_reg;
      end
   end

   rss_glitch_filter u_filt (
      .core_clk(core_clk),
      .srst(srst),
      .raw_lvl(sync2_reg[2]),
      .filt_lvl(pin_filt)
   );

   // ***************************
   // Registers and qualification
   // ***************************
   rss_cfg_t cfg_reg;
   rss_pwrctl_t power_control_reg;
   rss_core_t core_reg;
   logic [RSS_EV_W-1:0] irq_stat_reg;
   logic [RSS_EV_W-1:0] irq_mask_reg;
   rss_state_t state_reg;
   rss_state_t state_next;
   logic pend_pwrt_reg;
   logic [3:0] delay_reg;

   logic std_mon_on;
   logic std_low;
   logic lp_low;
   logic brownout_active;
   logic pin_en;
   logic pin_held;
   logic stk_fault;
   logic pulse_rst;
   logic hold_req;
   logic pwrt_start;
   logic [RSS_EV_W-1:0] ev;

   assign std_mon_on = (cfg_reg.supply_monitor_mode != RSS_MODE_OFF)
      && !((cfg_reg.supply_monitor_mode == RSS_MODE_SLEEP_OFF) && sleep_active);
   assign std_low = std_mon_on & ~sync2_reg[0];
   assign lp_low = cfg_reg.low_power_supply_monitor & ~sync2_reg[1];
   assign brownout_active = std_low | lp_low;
   assign pin_en = cfg_reg.ext_reset_pin_enable | cfg_reg.low_voltage_program_enable;
   assign pin_held = pin_en & ~pin_filt;
   assign stk_fault = cfg_reg.stack_fault_reset_enable
      & (reset_src.stack_over | reset_src.stack_under);
   assign pulse_rst = reset_src.watchdog_timeout | reset_src.reset_instr | stk_fault
      | reset_src.prog_exit;
   assign hold_req = brownout_active | pin_held | pulse_rst;
   assign pwrt_start = (state_reg == ST_HOLD) && (state_next == ST_PWRT);

   assign ev[RSS_EV_BROWNOUT] = brownout_active;
   assign ev[RSS_EV_PIN] = pin_held;
   assign ev[RSS_EV_WATCHDOG] = reset_src.watchdog_timeout;
   assign ev[RSS_EV_INSTR] = reset_src.reset_instr;
   assign ev[RSS_EV_OVER] = cfg_reg.stack_fault_reset_enable & reset_src.stack_over;
   assign ev[RSS_EV_UNDER] = cfg_reg.stack_fault_reset_enable & reset_src.stack_under;
   assign ev[RSS_EV_PROG] = reset_src.prog_exit;

   rss_powerup_timer #(
      .PWRT_CYCLES(PWRT_CYCLES)
   ) u_pwrt (
      .core_clk(core_clk),
      .srst(srst),
      .start(pwrt_start),
      .enable(cfg_reg.powerup_delay_enable),
      .done(pwrt_done)
   );

   // ***************************
   // APB decode
   // ***************************
   logic wr_acc;
   logic rd_setup;
   logic addr_ok;
   logic [31:0] rd_mux;

   assign wr_acc = psel & penable & pready & pwrite & pstrb[0];
   assign rd_setup = psel & ~penable;
   assign addr_ok = (paddr == RSS_ADDR_CFG) || (paddr == RSS_ADDR_PWRCTL)
      || (paddr == RSS_ADDR_CORE) || (paddr == RSS_ADDR_IRQ_STAT)
      || (paddr == RSS_ADDR_IRQ_MASK) || (paddr == RSS_ADDR_STATE);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         RSS_ADDR_CFG: rd_mux[7:0] = cfg_reg;
         RSS_ADDR_PWRCTL: rd_mux[4:0] = power_control_reg;
         RSS_ADDR_CORE: rd_mux[1:0] = core_reg;
         RSS_ADDR_IRQ_STAT: rd_mux[RSS_EV_W-1:0] = irq_stat_reg;
         RSS_ADDR_IRQ_MASK: rd_mux[RSS_EV_W-1:0] = irq_mask_reg;
         RSS_ADDR_STATE: rd_mux[7:0] = {pin_filt, pwrt_done, pend_pwrt_reg, core_reset, 4'(state_reg)};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= rd_setup;
         pslverr <= rd_setup & ~addr_ok;
         if (rd_setup && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // ***************************
   // Configuration and interrupt mask
   // ***************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg_reg <= RSS_CFG_RST;
         irq_mask_reg <= '0;
      end else if (wr_acc && paddr == RSS_ADDR_CFG) begin
         cfg_reg <= pwdata[7:0];
      end else if (wr_acc && paddr == RSS_ADDR_IRQ_MASK) begin
         irq_mask_reg <= pwdata[RSS_EV_W-1:0];
      end
   end

   // ***************************
   // Cause flags: writes load them, events set or clear them, events win over writes
   // ***************************
   rss_pwrctl_t power_control_next;
   rss_core_t core_next;

   always_comb begin
      power_control_next = power_control_reg;
      if (wr_acc && paddr == RSS_ADDR_PWRCTL) begin
         power_control_next = pwdata[4:0];
      end
      if (brownout_active) begin
         power_control_next.brownout_cause_flag = 1'b0;
      end
      if (reset_src.reset_instr) begin
         power_control_next.reset_instr_flag = 1'b0;
      end
      if (ev[RSS_EV_OVER]) begin
         power_control_next.stack_over_flag = 1'b1;
      end
      if (ev[RSS_EV_UNDER]) begin
         power_control_next.stack_under_flag = 1'b1;
      end
      if (reset_src.prog_exit) begin
         power_control_next = RSS_PWRCTL_RST;
      end
   end

   always_comb begin
      core_next = core_reg;
      if (wr_acc && paddr == RSS_ADDR_CORE) begin
         core_next = pwdata[1:0];
      end
      if (reset_src.watchdog_timeout) begin
         core_next.watchdog_expired_flag = 1'b0;
         core_next.powerdown_flag = 1'b1;
      end
      if (reset_src.prog_exit) begin
         core_next = RSS_CORE_RST;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         power_control_reg <= RSS_PWRCTL_RST;
         core_reg <= RSS_CORE_RST;
      end else begin
         power_control_reg <= power_control_next;
         core_reg <= core_next;
      end
   end

   // ***************************
   // Interrupt status, write one to clear
   // ***************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_stat_reg <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_acc && paddr == RSS_ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[RSS_EV_W-1:0]) | ev;
         end else begin
            irq_stat_reg <= irq_stat_reg | ev;
         end
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ***************************
   // Start-up sequence
   // ***************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD: begin
            // Timer is not held off by the pin, only by the supply or a pulse
            if (pend_pwrt_reg && !brownout_active && !pulse_rst) begin
               state_next = ST_PWRT;
            end else if (!hold_req) begin
               state_next = ST_RUN;
            end
         end
         ST_PWRT: begin
            if (brownout_active || pulse_rst) begin
               state_next = ST_HOLD;
            end else if (pwrt_done) begin
               state_next = pin_held ? ST_PIN : ST_RUN;
            end
         end
         ST_PIN: begin
            if (brownout_active || pulse_rst) begin
               state_next = ST_HOLD;
            end else if (!pin_held) begin
               state_next = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (hold_req) begin
               state_next = ST_HOLD;
            end else if (delay_reg == RSS_START_DELAY - 4'h1) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (hold_req) begin
               state_next = ST_HOLD;
            end
         end
         default: state_next = ST_HOLD;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= ST_HOLD;
         delay_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_DELAY) begin
            delay_reg <= delay_reg + 4'h1;
         end else begin
            delay_reg <= 4'h0;
         end
      end
   end

   // Power-on class events arm the power-up timer for the next release
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pend_pwrt_reg <= 1'b1;
      end else if (brownout_active || reset_src.prog_exit) begin
         pend_pwrt_reg <= 1'b1;
      end else if (pwrt_start) begin
         pend_pwrt_reg <= 1'b0;
      end
   end

   // ***************************
   // Outputs
   // ***************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         core_reset <= 1'b1;
         ext_reset_pin_out <= 1'b0;
         ext_reset_pin_oe <= 1'b0;
         ext_reset_pin_pullup <= 1'b1;
         gpio_in_lvl <= 1'b1;
      end else begin
         core_reset <= (state_next != ST_RUN);
         ext_reset_pin_out <= 1'b0;
         ext_reset_pin_oe <= 1'b0;
         ext_reset_pin_pullup <= pin_en | cfg_reg.gpio_pullup_sw;
         gpio_in_lvl <= pin_en ? 1'b1 : sync2_reg[2];
      end
   end
endmodule // rss_sequencer

// [test/rss_sequencer_properties.sv]
`timescale 1ns/1ns
module rss_sequencer_properties
   import rss_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic supply_low_async,
   input wire logic ext_reset_pin_out,
   input wire logic ext_reset_pin_oe,
   input wire rss_src_t reset_src,
   input wire logic core_reset
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // ****************
   // Sequences
   // ****************
   sequence hard_pulse;
      reset_src.watchdog_timeout || reset_src.reset_instr || reset_src.prog_exit;
   endsequence
   sequence reset_follows;
      ##1 core_reset;
   endsequence
   sequence setup_phase;
      psel && !penable;
   endsequence
   // ****************
   // Assertions
   // ****************
   a_pulse_resets: assert property (hard_pulse |-> reset_follows)
      else $error("reset pulse not followed by core reset");
   a_supply_holds: assert property (supply_low_async [*4] |-> core_reset)
      else $error("low supply without core reset");
   a_pin_undriven: assert property (!ext_reset_pin_oe)
      else $error("reset pin output enabled");
   a_pin_out_low: assert property (!ext_reset_pin_out)
      else $error("reset pin output level set");
   a_setup_answer: assert property (setup_phase |=> pready)
      else $error("no answer after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule // rss_sequencer_properties

// [test/rss_partner.sv]
`timescale 1ns/1ns
module rss_partner
   import rss_pkg::*;
(
   input wire logic core_clk,
   input wire logic pin_hold,
   input wire logic sup_req,
   input wire logic lp_req,
   input wire logic ext_reset_pin_out,
   input wire logic ext_reset_pin_oe,
   input wire logic ext_reset_pin_pullup,
   output logic ext_reset_pin_in,
   output logic supply_low_async,
   output logic lp_supply_low_async
);
   logic float_lvl = 1'b0;
   // Undriven pin without pull-up wanders
   always @(posedge core_clk) float_lvl <= ~float_lvl;
   assign ext_reset_pin_in = ext_reset_pin_oe ? ext_reset_pin_out : pin_hold ? 1'b0 :
      ext_reset_pin_pullup ? 1'b1 : float_lvl;
   assign supply_low_async = sup_req;
   assign lp_supply_low_async = lp_req;
endmodule // rss_partner

// [test/test_rss_sequencer.sv]
`timescale 1ns/1ns
module test_rss_sequencer
   import rss_pkg::*;
;
   localparam int PWRT = 20;
   logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, rerr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, sup_low = 0, lp_low = 0, sleep_active = 0, pin_hold = 0;
   logic pin_in, pin_out, pin_oe, pin_pullup, gpio_in_lvl, core_reset, irq, sup_a, lp_a;
   rss_src_t reset_src = '0;
   int mismatches = 0, n_checks = 0, n;
   rss_sequencer #(.PWRT_CYCLES(PWRT)) rss_sequencer_i(.core_clk(core_clk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_low_async(sup_a), .lp_supply_low_async(lp_a), .sleep_active(sleep_active),
      .ext_reset_pin_in(pin_in), .ext_reset_pin_out(pin_out), .ext_reset_pin_oe(pin_oe),
      .ext_reset_pin_pullup(pin_pullup), .gpio_in_lvl(gpio_in_lvl), .reset_src(reset_src),
      .core_reset(core_reset), .irq(irq));
   rss_partner rss_partner_i(.core_clk(core_clk), .pin_hold(pin_hold), .sup_req(sup_low),
      .lp_req(lp_low), .ext_reset_pin_out(pin_out), .ext_reset_pin_oe(pin_oe),
      .ext_reset_pin_pullup(pin_pullup), .ext_reset_pin_in(pin_in),
      .supply_low_async(sup_a), .lp_supply_low_async(lp_a));
   // ****************
   // Helpers
   // ****************
   initial forever #5 core_clk = ~core_clk;
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic pulse(input rss_src_t s);
      @(posedge core_clk) reset_src <= s;
      @(posedge core_clk) reset_src <= '0;
      @(posedge core_clk);
   endtask
   task automatic wait_run();
      n = 0;
      while (core_reset !== 1'b0 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      chk("release", 0, core_reset);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_regs();
      bus(0, RSS_ADDR_CFG, 0);
      chk("cfg", 32'h3E, rdat);
      bus(0, RSS_ADDR_PWRCTL, 0);
      chk("pwrctl", 32'h0D, rdat);
      bus(0, RSS_ADDR_STATE, 0);
      chk("state", 32'hC4, rdat);
      bus(0, RSS_ADDR_CORE, 0);
      chk("core", 32'h3, rdat);
      bus(0, 8'h20, 32'hFF);
      chk("slverr", 1, rerr);
      chk("unmapped", 0, rdat);
      chk("pullup", 1, pin_pullup);
      $display("regs done");
   endtask
   task automatic t_events();
      bus(1, RSS_ADDR_IRQ_MASK, 32'h04);
      pulse(5'h02);
      chk("instr reset", 1, core_reset);
      wait_run();
      bus(0, RSS_ADDR_PWRCTL, 0);
      chk("instr flag", 0, rdat[2]);
      chk("irq masked", 0, irq);
      pulse(5'h01);
      chk("wdt reset", 1, core_reset);
      wait_run();
      bus(0, RSS_ADDR_CORE, 0);
      chk("wdt flags", 32'h1, rdat);
      chk("irq set", 1, irq);
      bus(0, RSS_ADDR_PWRCTL, 0);
      chk("flag kept", 0, rdat[2]);
      bus(0, RSS_ADDR_IRQ_STAT, 0);
      chk("irq stat", 32'h0C, rdat);
      bus(1, RSS_ADDR_IRQ_STAT, 32'h0C);
      cyc(2);
      chk("irq clear", 0, irq);
      pulse(5'h04);
      chk("over reset", 1, core_reset);
      wait_run();
      bus(0, RSS_ADDR_PWRCTL, 0);
      chk("over flag", 1, rdat[4]);
      pulse(5'h10);
      chk("prog reset", 1, core_reset);
      wait_run();
      bus(0, RSS_ADDR_PWRCTL, 0);
      chk("prog flags", 32'h0D, rdat);
      bus(1, RSS_ADDR_CFG, 32'h1E);
      pulse(5'h08);
      chk("stack off", 0, core_reset);
      $display("events done");
   endtask
   task automatic t_brown();
      bus(1, RSS_ADDR_CFG, 32'h3D);
      sleep_active <= 1;
      lp_low <= 1;
      cyc(10);
      chk("lp hold", 1, core_reset);
      bus(0, RSS_ADDR_PWRCTL, 0);
      chk("lp flag", 0, rdat[0]);
      lp_low <= 0;
      sleep_active <= 0;
      wait_run();
      chk("lp release", 1, n < 10);
      bus(1, RSS_ADDR_CFG, 32'h3E);
      bus(1, RSS_ADDR_PWRCTL, 32'h0D);
      sup_low <= 1;
      cyc(6);
      sup_low <= 0;
      wait_run();
      bus(0, RSS_ADDR_PWRCTL, 0);
      chk("std flag", 0, rdat[0]);
      $display("brownout done");
   endtask
   task automatic t_timer();
      bus(1, RSS_ADDR_CFG, 32'h7E);
      sup_low <= 1;
      cyc(6);
      sup_low <= 0;
      wait_run();
      chk("pwrt", 1, n >= PWRT && n <= PWRT + 8);
      pin_hold <= 1;
      sup_low <= 1;
      cyc(6);
      sup_low <= 0;
      cyc(2 * PWRT);
      chk("pin holds", 1, core_reset);
      pin_hold <= 0;
      wait_run();
      chk("late pin", 1, n >= RSS_FILT_CYCLES + 10 && n <= RSS_FILT_CYCLES + 16);
      $display("timer done");
   endtask
   task automatic t_pin();
      @(posedge core_clk) pin_hold <= 1;
      @(posedge core_clk) pin_hold <= 0;
      cyc(6);
      chk("glitch", 0, core_reset);
      for (int k = 0; k < 4; k++) begin
         bus(1, RSS_ADDR_CFG, 32'h26 | (k << 3));
         pin_hold <= 1;
         cyc(RSS_FILT_CYCLES + 6);
         chk("pin reset", k != 0, core_reset);
         chk("pin pullup", k != 0, pin_pullup);
         chk("gpio", k != 0, gpio_in_lvl);
         pin_hold <= 0;
         wait_run();
      end
      bus(1, RSS_ADDR_CFG, 32'hA6);
      cyc(2);
      chk("sw pullup", 1, pin_pullup);
      $display("pin done");
   endtask
   initial begin
      #200000;
      mismatches++;
      conclude();
   end
   initial begin
      cyc(16);
      srst <= 0;
      wait_run();
      chk("start", 0, core_reset);
      t_regs();
      t_events();
      t_brown();
      t_timer();
      t_pin();
      conclude();
   end
endmodule // test_rss_sequencer
bind rss_sequencer rss_sequencer_properties rss_sequencer_properties_i(.core_clk(core_clk),
   .srst(srst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .supply_low_async(supply_low_async), .ext_reset_pin_out(ext_reset_pin_out),
   .ext_reset_pin_oe(ext_reset_pin_oe), .reset_src(reset_src), .core_reset(core_reset));
